/* hdl/epv_map.svh */
// Constant map of the exception priority and vectoring unit
`ifndef EPV_MAP_SVH
`define EPV_MAP_SVH
// ============================================================
// Behaviour
// - IRQ lines 0 to 81 are interrupt exceptions, each with its own handler.
// - Table entry 0 is the reset stack pointer, then every handler start address.
// - Interrupt vector entries are consecutive words, 4 bytes apart.
// - After reset vectors come from a table based at 0x00000000.
// - Privileged base register write relocates table within 0x00000000 to 0x3FFFFF80.
// - A smaller priority value is more urgent.
// - Reset, hard fault and NMI are fixed; all others are configurable.
// - Configurable priorities reset to 0.
// - Configurable priorities span 0-15; fixed negative ones always win.
// - Equal priority pending exceptions go lowest exception number first.
// - Only strictly higher priority preempts; equal priority just stays pending.
// - Each priority entry splits into group priority and subpriority fields.
// - Preemption between interrupts uses group priority only.
// - Equal group orders by subpriority, then lowest interrupt number.
// - Return with nothing to chain unstacks and resumes the saved context.
// - A qualifying pending exception at return is tail-chained without unstacking.
// - Higher priority arrival during stacking redirects the vector fetch only.
// - Late arrival accepted until the first handler instruction reaches execute.
// - After a late arrival handler returns, normal tail-chaining applies.
// - NMI always enabled, priority -2, preempted only by reset.
// - Hard fault has fixed priority -1 above all configurable ones.
// - Entry needs priority above mask and thread mode or beating current handler.

// ============================================================
// Sizes
`define EPV_NUM_IRQ    82
`define EPV_NUM_EXC    98
`define EPV_NUM_SYS    6
`define EPV_NEST_D     18
`define EPV_SPLIT_W    3
// ============================================================
// Exception numbers
`define EPV_EXC_RST    7'h01
`define EPV_EXC_NMI    7'h02
`define EPV_EXC_HF     7'h03
`define EPV_EXC_MEM    7'h04
`define EPV_EXC_BUS    7'h05
`define EPV_EXC_USE    7'h06
`define EPV_EXC_SVC    7'h0B
`define EPV_EXC_PSV    7'h0E
`define EPV_EXC_SYT    7'h0F
`define EPV_IRQ_BASE   16
// ============================================================
// Priority keys and reset values
`define EPV_KEY_NMI    5'h00
`define EPV_KEY_HF     5'h01
`define EPV_KEY_NONE   5'h1F
`define EPV_PRI_RST    4'h0
`define EPV_SPLIT_RST  3'h0
`define EPV_VECTOR_TABLE_BASE_REGISTER_RST   32'h0000_0000
`define EPV_VECTOR_TABLE_BASE_REGISTER_MASK  32'h3FFF_FF80
// ============================================================
// Register offsets
`define EPV_OFS_VECTOR_TABLE_BASE_REGISTER   8'h00
`define EPV_OFS_CTRL   8'h04
`define EPV_OFS_STAT   8'h08
`define EPV_OFS_SPRI0  8'h10
`define EPV_OFS_SPRI1  8'h14
`define EPV_OFS_IPRI   8'h20
`define EPV_OFS_IPRIE  8'h48
`endif

/* hdl/epv_pkg.sv */
// Types of the exception priority and vectoring unit
package epv_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    EPV_BOOT_SP,
    EPV_BOOT_PC,
    EPV_RUN,
    EPV_STACK,
    EPV_FETCH,
    EPV_UNSTACK
  } epv_state_t;

  // Arbitration winner
  typedef struct packed {
    logic       valid;
    logic [6:0] num;
    logic [4:0] key;
  } epv_win_t;

  // Vector fetch request
  typedef struct packed {
    logic        req;
    logic        sp;
    logic [6:0]  num;
    logic [31:0] addr;
  } epv_vec_t;
endpackage : epv_pkg

/* hdl/epv_arbiter.sv */
// Pending exception arbiter: lowest key, then lowest number
`include "epv_map.svh"
module epv_arbiter
  import epv_pkg::*;
(
  input  wire logic [`EPV_NUM_EXC-1:0]      pend,
  input  wire logic [`EPV_NUM_EXC-1:0][4:0] key,
  output epv_win_t                          win
);
  // ============================================================
  // Selection
  // Ascending scan with strict compare keeps the lowest number on ties
  always_comb begin : pick
    win = '0;
    for (int i = 0; i < `EPV_NUM_EXC; i++) begin
      if (pend[i] && (!win.valid || key[i] < win.key)) begin
        win.valid = 1'b1;
        win.num   = 7'(i);
        win.key   = key[i];
      end
    end
  end
endmodule : epv_arbiter

/* hdl/epv_unit.sv */
// Exception priority, preemption and vectoring unit
//
// The register addresses and the plain strobed port were left to the implementer.
`include "epv_map.svh"
module epv_unit
  import epv_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic [`EPV_NUM_IRQ-1:0] irq_pin,
  input  wire logic                    nmi_pin,
  input  wire logic                    hf_req,
  input  wire logic [`EPV_NUM_SYS-1:0] sys_req,
  input  wire logic                    priv,
  input  wire logic [4:0]              mask_lvl,
  input  wire logic                    stack_done,
  input  wire logic                    first_exec,
  input  wire logic                    exc_done,
  input  wire logic                    unstack_done,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output epv_vec_t                     vec,
  output logic                         stack_req,
  output logic                         tail_chain,
  output logic                         unstack_req,
  output logic                         late_arrival,
  output logic                         handler_mode,
  output logic      [6:0]              cur_num
);
  // ============================================================
  // Declarations
  logic [`EPV_NUM_IRQ-1:0]      irq_s1;
  logic [`EPV_NUM_IRQ-1:0]      irq_s2;
  logic [`EPV_NUM_IRQ-1:0]      irq_s3;
  logic                         nmi_s1;
  logic                         nmi_s2;
  logic                         nmi_s3;
  logic [31:0]                  vector_table_base_register;
  logic [`EPV_SPLIT_W-1:0]      split;
  logic [3:0]                   sys_pri [`EPV_NUM_SYS];
  logic [3:0]                   irq_pri [`EPV_NUM_IRQ];
  logic [`EPV_NUM_EXC-1:0]      pend;
  logic [`EPV_NUM_EXC-1:0]      set_vec;
  logic [`EPV_NUM_EXC-1:0]      clr_vec;
  logic [`EPV_NUM_EXC-1:0][4:0] key;
  epv_win_t                     win;
  epv_state_t                   state;
  logic [6:0]                   target;
  logic                         chain;
  logic [6:0]                   nest [`EPV_NEST_D];
  logic [4:0]                   depth;
  logic [4:0]                   depth_m1;
  logic [4:0]                   win_g;
  logic [4:0]                   cur_g;
  logic [4:0]                   prev_g;
  logic [4:0]                   tgt_g;
  logic                         elig;
  logic                         take;
  logic                         chain_ok;
  logic                         late;
  logic                         ipri_hit;
  logic [3:0]                   ipri_idx;
  logic [31:0]                  rd_word;

  // ============================================================
  // Functions
  // Group key: fixed keys pass, configurable ones lose their sub bits
  function automatic logic [4:0] grp(input logic [4:0] k, input logic [2:0] s);
    logic [3:0] m;
    m   = 4'hF << ((s > 3'h4) ? 3'h4 : s);
    grp = k[4] ? {1'b1, k[3:0] & m} : k;
  endfunction : grp

  // Vector entry address, one word per exception number
  function automatic epv_vec_t vfetch(input logic [6:0] n);
    vfetch.req  = 1'b1;
    vfetch.sp   = 1'b0;
    vfetch.num  = n;
    vfetch.addr = vector_table_base_register + {23'h00_0000, n, 2'b00};
  endfunction : vfetch

  // Exception number of each configurable system request
  function automatic logic [6:0] sys_num(input int i);
    case (i)
      0:       sys_num = `EPV_EXC_MEM;
      1:       sys_num = `EPV_EXC_BUS;
      2:       sys_num = `EPV_EXC_USE;
      3:       sys_num = `EPV_EXC_SVC;
      4:       sys_num = `EPV_EXC_PSV;
      default: sys_num = `EPV_EXC_SYT;
    endcase
  endfunction : sys_num

  // ============================================================
  // Input synchronisers and edge detect
  always_ff @(posedge clk_sys or negedge rstn) begin : sync
    if (!rstn) begin
      irq_s1 <= '0;
      irq_s2 <= '0;
      irq_s3 <= '0;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_s3 <= 1'b0;
    end else begin
      irq_s1 <= irq_pin;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      nmi_s1 <= nmi_pin;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end

  // ============================================================
  // Pending state
  // Request sources mapped onto exception numbers
  always_comb begin : sets
    set_vec = '0;
    set_vec[`EPV_EXC_NMI] = nmi_s2 & ~nmi_s3;
    set_vec[`EPV_EXC_HF]  = hf_req;
    for (int i = 0; i < `EPV_NUM_SYS; i++) begin
      set_vec[sys_num(i)] = sys_req[i];
    end
    for (int i = 0; i < `EPV_NUM_IRQ; i++) begin
      set_vec[`EPV_IRQ_BASE + i] = irq_s2[i] & ~irq_s3[i];
    end
  end

  // Pending bit drops only when its handler really starts
  assign clr_vec = (state == EPV_FETCH && first_exec) ?
                   (`EPV_NUM_EXC'(1) << target) : '0;

  // New request wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin : pending
    if (!rstn) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~clr_vec) | set_vec;
    end
  end

  // ============================================================
  // Priority keys and arbitration
  // Fixed sources sit below every configurable key {1,p}
  always_comb begin : keys
    for (int i = 0; i < `EPV_NUM_EXC; i++) begin
      if (i >= `EPV_IRQ_BASE) begin
        key[i] = {1'b1, irq_pri[i - `EPV_IRQ_BASE]};
      end else begin
        key[i] = `EPV_KEY_NONE;
      end
    end
    key[`EPV_EXC_NMI] = `EPV_KEY_NMI;
    key[`EPV_EXC_HF]  = `EPV_KEY_HF;
    for (int i = 0; i < `EPV_NUM_SYS; i++) begin
      key[sys_num(i)] = {1'b1, sys_pri[i]};
    end
  end

  epv_arbiter u_arb (
    .pend (pend),
    .key  (key),
    .win  (win)
  );

  // Group keys of winner, running handler, outer context and target
  assign depth_m1 = (depth == 5'h00) ? 5'h00 : depth - 5'h01;
  assign win_g    = grp(win.key, split);
  assign cur_g    = grp(key[cur_num], split);
  assign prev_g   = grp(key[nest[depth_m1]], split);
  assign tgt_g    = grp(key[target], split);

  // Mask limits apply to configurable sources only
  assign elig = win.valid && (!win.key[4] || win_g < mask_lvl);
  // Strictly higher group needed to preempt
  assign take = elig && (!handler_mode || win_g < cur_g);
  // At return, compare against the context that would resume
  assign chain_ok = elig && (depth == 5'h00 || win_g < prev_g);
  // Late arrival must beat the exception being entered
  assign late = elig && win_g < tgt_g;

  // ============================================================
  // Entry, late arrival, tail-chain and return sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin : fsm
    if (!rstn) begin
      state        <= EPV_BOOT_SP;
      target       <= 7'h00;
      chain        <= 1'b0;
      vec          <= '0;
      stack_req    <= 1'b0;
      tail_chain   <= 1'b0;
      unstack_req  <= 1'b0;
      late_arrival <= 1'b0;
    end else begin
      vec.req      <= 1'b0;
      stack_req    <= 1'b0;
      tail_chain   <= 1'b0;
      unstack_req  <= 1'b0;
      late_arrival <= 1'b0;
      case (state)
        EPV_BOOT_SP: begin
          vec    <= vfetch(7'h00);
          vec.sp <= 1'b1;
          state  <= EPV_BOOT_PC;
        end
        EPV_BOOT_PC: begin
          vec   <= vfetch(`EPV_EXC_RST);
          state <= EPV_RUN;
        end
        EPV_RUN: begin
          if (exc_done && handler_mode) begin
            if (chain_ok) begin
              tail_chain <= 1'b1;
              target     <= win.num;
              chain      <= 1'b1;
              vec        <= vfetch(win.num);
              state      <= EPV_FETCH;
            end else begin
              unstack_req <= 1'b1;
              state       <= EPV_UNSTACK;
            end
          end else if (take) begin
            stack_req <= 1'b1;
            target    <= win.num;
            chain     <= 1'b0;
            vec       <= vfetch(win.num);
            state     <= EPV_STACK;
          end
        end
        EPV_STACK: begin
          if (late) begin
            target       <= win.num;
            late_arrival <= 1'b1;
            vec          <= vfetch(win.num);
          end
          if (stack_done) begin
            state <= EPV_FETCH;
          end
        end
        EPV_FETCH: begin
          if (first_exec) begin
            state <= EPV_RUN;
          end else if (late) begin
            target       <= win.num;
            late_arrival <= 1'b1;
            vec          <= vfetch(win.num);
          end
        end
        EPV_UNSTACK: begin
          if (unstack_done) begin
            state <= EPV_RUN;
          end
        end
        default: begin
          state <= EPV_RUN;
        end
      endcase
    end
  end

  // ============================================================
  // Running context and nesting stack
  always_ff @(posedge clk_sys or negedge rstn) begin : ctx
    if (!rstn) begin
      cur_num      <= 7'h00;
      handler_mode <= 1'b0;
      depth        <= 5'h00;
      for (int i = 0; i < `EPV_NEST_D; i++) begin
        nest[i] <= 7'h00;
      end
    end else if (state == EPV_FETCH && first_exec) begin
      if (handler_mode && !chain) begin
        nest[depth] <= cur_num;
        depth       <= depth + 5'h01;
      end
      cur_num      <= target;
      handler_mode <= 1'b1;
    end else if (state == EPV_UNSTACK && unstack_done) begin
      if (depth == 5'h00) begin
        handler_mode <= 1'b0;
        cur_num      <= 7'h00;
      end else begin
        cur_num <= nest[depth_m1];
        depth   <= depth_m1;
      end
    end
  end

  // ============================================================
  // Register writes
  assign ipri_hit = reg_addr >= `EPV_OFS_IPRI && reg_addr <= `EPV_OFS_IPRIE &&
                    reg_addr[1:0] == 2'b00;
  assign ipri_idx = 4'((reg_addr - `EPV_OFS_IPRI) >> 2);

  always_ff @(posedge clk_sys or negedge rstn) begin : regs
    if (!rstn) begin
      vector_table_base_register  <= `EPV_VECTOR_TABLE_BASE_REGISTER_RST;
      split <= `EPV_SPLIT_RST;
      for (int i = 0; i < `EPV_NUM_SYS; i++) begin
        sys_pri[i] <= `EPV_PRI_RST;
      end
      for (int i = 0; i < `EPV_NUM_IRQ; i++) begin
        irq_pri[i] <= `EPV_PRI_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr == `EPV_OFS_VECTOR_TABLE_BASE_REGISTER) begin
        if (priv) begin
          vector_table_base_register <= reg_wdata & `EPV_VECTOR_TABLE_BASE_REGISTER_MASK;
        end
      end else if (reg_addr == `EPV_OFS_CTRL) begin
        split <= reg_wdata[`EPV_SPLIT_W-1:0];
      end else if (reg_addr == `EPV_OFS_SPRI0) begin
        for (int i = 0; i < 4; i++) begin
          sys_pri[i] <= reg_wdata[4*i +: 4];
        end
      end else if (reg_addr == `EPV_OFS_SPRI1) begin
        for (int i = 0; i < 2; i++) begin
          sys_pri[4+i] <= reg_wdata[4*i +: 4];
        end
      end else if (ipri_hit) begin
        for (int j = 0; j < 8; j++) begin
          if (int'(ipri_idx) * 8 + j < `EPV_NUM_IRQ) begin
            irq_pri[int'(ipri_idx) * 8 + j] <= reg_wdata[4*j +: 4];
          end
        end
      end
    end
  end

  // ============================================================
  // Register reads
  always_comb begin : rd_mux
    rd_word = 32'h0000_0000;
    if (reg_addr == `EPV_OFS_VECTOR_TABLE_BASE_REGISTER) begin
      rd_word = vector_table_base_register;
    end else if (reg_addr == `EPV_OFS_CTRL) begin
      rd_word[`EPV_SPLIT_W-1:0] = split;
    end else if (reg_addr == `EPV_OFS_STAT) begin
      rd_word = {19'h0_0000, depth, handler_mode, cur_num};
    end else if (reg_addr == `EPV_OFS_SPRI0) begin
      for (int i = 0; i < 4; i++) begin
        rd_word[4*i +: 4] = sys_pri[i];
      end
    end else if (reg_addr == `EPV_OFS_SPRI1) begin
      for (int i = 0; i < 2; i++) begin
        rd_word[4*i +: 4] = sys_pri[4+i];
      end
    end else if (ipri_hit) begin
      for (int j = 0; j < 8; j++) begin
        if (int'(ipri_idx) * 8 + j < `EPV_NUM_IRQ) begin
          rd_word[4*j +: 4] = irq_pri[int'(ipri_idx) * 8 + j];
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin : rd_reg
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h0000_0000;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_VEC_STEP: assert property (
    vec.req |-> vec.addr == $past(vector_table_base_register) + {23'h00_0000, vec.num, 2'b00})
    else $error("vector address not base plus four per number");
  AST_BOOT_ORDER: assert property (
    vec.req && vec.sp |-> vec.num == 7'h00 ##1 vec.req && !vec.sp && vec.num == 7'h01)
    else $error("boot fetch order wrong");
  AST_VECTOR_TABLE_BASE_REGISTER_WRITE: assert property (
    reg_wr && priv && reg_addr == `EPV_OFS_VECTOR_TABLE_BASE_REGISTER |=>
      vector_table_base_register == ($past(reg_wdata) & `EPV_VECTOR_TABLE_BASE_REGISTER_MASK))
    else $error("table base not relocated");
  AST_PREEMPT_STRICT: assert property (
    stack_req && $past(handler_mode) |-> $past(win_g) < $past(cur_g))
    else $error("preemption without strictly higher group");
  AST_ENTRY_MASK: assert property (
    stack_req |-> $past(elig))
    else $error("entry of masked exception");
  AST_LATE_WINDOW: assert property (
    late_arrival |-> vec.req && (state == EPV_STACK || state == EPV_FETCH))
    else $error("late arrival outside entry");
  AST_LATE_CUTOFF: assert property (
    state == EPV_FETCH && first_exec |=> !late_arrival && state == EPV_RUN)
    else $error("late arrival after first instruction");
  AST_RETURN_PATH: assert property (
    state == EPV_RUN && exc_done && handler_mode |=> tail_chain != unstack_req)
    else $error("return took neither or both paths");
endmodule : epv_unit

/* verif/epv_core_model.sv */
// Behavioural model of the pipeline and stacking unit beside the exception unit
module epv_core_model #(
  parameter int RUN_CYC = 30
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       stack_req,
  input  wire logic       tail_chain,
  input  wire logic       unstack_req,
  input  wire logic       handler_mode,
  input  wire logic [3:0] lag,
  output logic            stack_done,
  output logic            first_exec,
  output logic            exc_done,
  output logic            unstack_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] st;
  logic [5:0] cnt;
  // ============================================================
  // Sequencer: stack, enter, run, return, unstack
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st           <= 3'h0;
      cnt          <= 6'h00;
      stack_done   <= 1'b0;
      first_exec   <= 1'b0;
      exc_done     <= 1'b0;
      unstack_done <= 1'b0;
    end else begin
      stack_done   <= 1'b0;
      first_exec   <= 1'b0;
      exc_done     <= 1'b0;
      unstack_done <= 1'b0;
      if (stack_req) begin
        st  <= 3'h1;
        cnt <= {2'b00, lag};
      end else if (tail_chain) begin
        st  <= 3'h2;
        cnt <= 6'h01;
      end else if (unstack_req) begin
        st  <= 3'h4;
        cnt <= {2'b00, lag};
      end else if (cnt != 6'h00) begin
        cnt <= cnt - 6'h01;
      end else begin
        case (st)
          3'h1: begin
            stack_done <= 1'b1;
            st         <= 3'h2;
            cnt        <= 6'h01;
          end
          3'h2: begin
            first_exec <= 1'b1;
            st         <= 3'h3;
            cnt        <= 6'(RUN_CYC);
          end
          3'h3: begin
            exc_done <= 1'b1;
            st       <= 3'h0;
          end
          3'h4: begin
            unstack_done <= 1'b1;
            st           <= 3'h5;
            cnt          <= 6'h01;
          end
          3'h5: begin
            st  <= handler_mode ? 3'h3 : 3'h0; // Outer handler resumes
            cnt <= 6'(RUN_CYC);
          end
          default: st <= 3'h0;
        endcase
      end
    end
  end
endmodule : epv_core_model

/* verif/exception_priority_and_vectoring_bench.sv */
// Self-checking bench of the exception priority and vectoring unit
module exception_priority_and_vectoring_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys   = 1'b0;
  logic              rstn      = 1'b0;
  logic [81:0]       irq_pin   = '0;
  logic              nmi_pin   = 1'b0;
  logic              hf_req    = 1'b0;
  logic [5:0]        sys_req   = '0;
  logic              priv      = 1'b0;
  logic [4:0]        mask_lvl  = 5'h1F;
  logic [7:0]        reg_addr  = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [3:0]        lag       = 4'h1;
  logic [31:0]       reg_rdata;
  epv_pkg::epv_vec_t vec;
  logic              stack_req, tail_chain, unstack_req, late_arrival, handler_mode;
  logic [6:0]        cur_num;
  logic              stack_done, first_exec, exc_done, unstack_done;
  logic              rd_d = 1'b0;
  logic [31:0]       base = '0;
  logic [39:0]       vq[$];
  logic [31:0]       rq[$];
  int                error_cnt = 0;
  int                n_compared = 0;
  int                n_stack = 0;
  int                n_chain = 0;
  int                n_unst = 0;
  int                n_late = 0;
  logic              fx_d = 1'b0;
  logic [39:0]       exp_v = '0;
  logic [31:0]       hpc = '0;
  int                cyc = 0;
  int                k;
  int                idle;
  int                n;
  logic [6:0]        sys_num[6] = '{7'h04, 7'h05, 7'h06, 7'h0B, 7'h0E, 7'h0F};

  always #20 clk_sys = ~clk_sys;

  epv_unit i_epv_unit (.clk_sys(clk_sys), .rstn(rstn), .irq_pin(irq_pin), .nmi_pin(nmi_pin),
    .hf_req(hf_req), .sys_req(sys_req), .priv(priv), .mask_lvl(mask_lvl),
    .stack_done(stack_done), .first_exec(first_exec), .exc_done(exc_done),
    .unstack_done(unstack_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec(vec),
    .stack_req(stack_req), .tail_chain(tail_chain), .unstack_req(unstack_req),
    .late_arrival(late_arrival), .handler_mode(handler_mode), .cur_num(cur_num));

  epv_core_model i_epv_core_model (.clk_sys(clk_sys), .rstn(rstn), .stack_req(stack_req),
    .tail_chain(tail_chain), .unstack_req(unstack_req), .handler_mode(handler_mode),
    .lag(lag), .stack_done(stack_done), .first_exec(first_exec), .exc_done(exc_done),
    .unstack_done(unstack_done));

  // ============================================================
  // Compare tasks and closing report
  task automatic cmp_vec(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t vector got %h exp %h", $time, got, exp);
    end
  endtask : cmp_vec

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t value got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ============================================================
  // Watcher: takes the oldest note whenever a result appears
  always @(posedge clk_sys) begin
    cyc++;
    if (vec.req === 1'b1) begin
      if (vq.size() == 0) begin
        error_cnt++;
        $display("mismatch %0t unexpected vector fetch", $time);
      end else begin
        exp_v = vq.pop_front();
        hpc   = {24'h00_0000, exp_v[38:32], 1'b1}; // Odd handler entry
        cmp_vec({vec.sp, vec.num, vec.addr}, exp_v);
      end
    end
    if (rd_d) cmp_reg(reg_rdata, rq.pop_front());
    if (fx_d) cmp_reg(32'(cur_num), hpc >> 1);
    rd_d <= reg_rd;
    fx_d <= first_exec;
    if (stack_req === 1'b1) n_stack++;
    if (tail_chain === 1'b1) n_chain++;
    if (unstack_req === 1'b1) n_unst++;
    if (late_arrival === 1'b1) n_late++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("mismatch %0t run hung", $time);
      wrap_up();
    end
  end

  // ============================================================
  // Drivers and expectation notes
  task automatic ex_vec(input logic [6:0] num);
    vq.push_back({1'b0, num, base + {23'h0, num, 2'b00}});
  endtask : ex_vec

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    priv      <= p;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back(exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask : rd

  task automatic fire(input logic [81:0] m);
    @(posedge clk_sys);
    irq_pin <= m;
    repeat (4) @(posedge clk_sys);
    irq_pin <= '0;
  endtask : fire

  task automatic settle();
    k = 0;
    idle = 0;
    while (idle < 24 && k < 800) begin
      @(posedge clk_sys);
      k++;
      idle = (vq.size() == 0 && handler_mode === 1'b0) ? idle + 1 : 0;
    end
    if (k >= 800) begin
      error_cnt++;
      $display("mismatch %0t no return to thread mode", $time);
    end
  endtask : settle

  // Second interrupt arrives while the first handler runs
  task automatic nest(input logic [31:0] split, input logic [31:0] exp_stk);
    int s0;
    int c0;
    int u0;
    wr(8'h04, split, 1'b1);
    s0 = n_stack;
    c0 = n_chain;
    u0 = n_unst;
    ex_vec(7'd19);
    fire(82'h8);
    repeat (6) @(posedge clk_sys);
    ex_vec(7'd20);
    fire(82'h10);
    settle();
    cmp_reg(32'(n_stack - s0), exp_stk);
    cmp_reg(32'(n_chain - c0), 32'h0000_0002 - exp_stk);
    cmp_reg(32'(n_unst - u0), exp_stk);
  endtask : nest

  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(32'h0d11));
    vq.push_back({1'b1, 7'h00, 32'h0000_0000});
    ex_vec(7'h01);
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h48, 32'h0000_0000);
    rd(8'hF0, 32'h0000_0000);
    wr(8'h00, 32'h0000_0100, 1'b0);
    rd(8'h00, 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF, 1'b1);
    rd(8'h00, 32'h3FFF_FF80);
    wr(8'h00, 32'h0000_0080, 1'b1);
    rd(8'h00, 32'h0000_0080);
    base = 32'h0000_0080;
    wr(8'h20, 32'h0001_2000, 1'b1);
    rd(8'h20, 32'h0001_2000);
    ex_vec(7'd20);
    ex_vec(7'd19);
    fire(82'h18);
    settle();
    ex_vec(7'd17);
    ex_vec(7'd18);
    fire(82'h6);
    settle();
    rd(8'h08, 32'h0000_0000);
    nest(32'h0000_0000, 32'h0000_0002);
    nest(32'h0000_0004, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      ex_vec(sys_num[i]);
      @(posedge clk_sys);
      sys_req <= 6'h01 << i;
      @(posedge clk_sys);
      sys_req <= '0;
      settle();
    end
    // Masked interrupt waits while fixed-priority sources still enter
    mask_lvl <= 5'h10;
    fire(82'h20);
    ex_vec(7'd3);
    @(posedge clk_sys);
    hf_req <= 1'b1;
    @(posedge clk_sys);
    hf_req <= 1'b0;
    settle();
    ex_vec(7'd2);
    @(posedge clk_sys);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    nmi_pin <= 1'b0;
    settle();
    ex_vec(7'd21);
    mask_lvl <= 5'h1F;
    settle();
    // Late arrival during slow stacking, then chain back to the original
    lag <= 4'h8;
    ex_vec(7'd16);
    ex_vec(7'd2);
    ex_vec(7'd16);
    n = n_late;
    @(posedge clk_sys);
    irq_pin <= 82'h1;
    k = 0;
    while (stack_req !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    nmi_pin <= 1'b1;
    irq_pin <= '0;
    repeat (4) @(posedge clk_sys);
    nmi_pin <= 1'b0;
    settle();
    cmp_reg(32'(n_late - n), 32'h0000_0001);
    lag <= 4'h1;
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 81 : $urandom_range(81, 0);
      ex_vec(7'(16 + n));
      fire(82'h1 << n);
      settle();
    end
    wrap_up();
  end
endmodule : exception_priority_and_vectoring_bench
